// ===== hdl/dgp_pkg.sv
// Shared constants, encodings and timing for the digitizer pixel and sync port
package dgp_pkg;
	localparam int CLK_NS = 10;
	// Pixel clock is mclk divided by four
	localparam logic [1:0] PIX_DIV_M1 = 2'h3;
	localparam logic [1:0] PIX_HALF = 2'h2;
	// Crystal clock rate made from mclk
	localparam int XTAL_NS = 40;
	localparam logic [1:0] XTAL_TGL_M1 = 2'((XTAL_NS / 2) / CLK_NS - 1);
	localparam logic [1:0] XTAL_HALF_TGL_M1 = 2'(XTAL_NS / CLK_NS - 1);
	// Sync processing, counted in pixels
	localparam logic [3:0] FRAME_DLY_PIX = 4'h8;
	localparam logic [11:0] LINE_SYNC_PIX = 12'h00c;
	localparam logic [7:0] BROAD_PIX = 8'h40;
	// Serial control port and link reset length
	localparam logic [6:0] ADDR_SEL_LOW = 7'h4c;
	localparam logic [6:0] ADDR_SEL_HIGH = 7'h4d;
	localparam int I2C_PERIOD_NS = 2500;
	localparam logic [7:0] I2C_QTR_M1 =
		8'((I2C_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [4:0] I2C_LAST_BIT = 5'h11;
	localparam int RST_LOW_NS = 1000;
	localparam logic [7:0] RST_LOW_CYC = 8'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
	// Control byte written over the serial port
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CTRL_DUAL = 0;
	localparam int CTRL_SRC = 1;
	localparam int CTRL_XHALF = 3;
	typedef enum logic [1:0] {dgp_src_line, dgp_src_green, dgp_src_comp} dgp_src_e;
	typedef enum {slv_idle, slv_addr, slv_acka, slv_wr, slv_ackw, slv_rd, slv_ackr} dgp_slv_e;
	typedef enum {mst_idle, mst_start, mst_bits, mst_stop} dgp_mst_e;
endpackage : dgp_pkg

// ===== hdl/dgp_link_if.sv
// Pin-level link between the digitizer and the pixel controller
`timescale 1ns/10ps
`default_nettype none
interface dgp_link_if;
	logic sample_phase_invert_in;
	logic link_rst_n;
	logic crystal_clock_buffer_out;
	logic bus_address_select;
	logic scl;
	logic sda_o_dev;
	logic sda_oe_dev;
	logic sda_o_ctl;
	logic sda_oe_ctl;
	logic sda;
	logic [7:0] red_pri;
	logic [7:0] red_sec;
	logic [7:0] grn_pri;
	logic [7:0] grn_sec;
	logic [7:0] blu_pri;
	logic [7:0] blu_sec;
	logic pixel_word_clock;
	logic pixel_word_clock_n;
	logic aligned_line_sync_out;
	logic synthetic_frame_sync_out;
	logic raw_line_sync_out;
	logic raw_frame_sync_out;
	// Open-drain wire with pull-up: low when either end pulls low
	assign sda = !((sda_oe_dev && !sda_o_dev) || (sda_oe_ctl && !sda_o_ctl));
	modport dev(
		input sample_phase_invert_in, link_rst_n, bus_address_select, scl, sda,
		output crystal_clock_buffer_out, sda_o_dev, sda_oe_dev,
		output red_pri, red_sec, grn_pri, grn_sec, blu_pri, blu_sec,
		output pixel_word_clock, pixel_word_clock_n, aligned_line_sync_out,
		output synthetic_frame_sync_out, raw_line_sync_out, raw_frame_sync_out
	);
	modport ctl(
		output sample_phase_invert_in, link_rst_n, bus_address_select, scl,
		output sda_o_ctl, sda_oe_ctl,
		input sda, crystal_clock_buffer_out,
		input red_pri, red_sec, grn_pri, grn_sec, blu_pri, blu_sec,
		input pixel_word_clock, pixel_word_clock_n, aligned_line_sync_out,
		input synthetic_frame_sync_out, raw_line_sync_out, raw_frame_sync_out
	);
endinterface : dgp_link_if
`default_nettype wire

// ===== hdl/dgp_sync2.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module dgp_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= INIT;
			q <= INIT;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : dgp_sync2
`default_nettype wire

// ===== hdl/dgp_device.sv
// Digitizer end: pixel buses, word clocks, sync outputs and serial control
`timescale 1ns/10ps
`default_nettype none
module dgp_device
	import dgp_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	dgp_link_if.dev link,
	input wire logic [7:0] adc_red,
	input wire logic [7:0] adc_green,
	input wire logic [7:0] adc_blue,
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	input wire logic green_embedded_sync,
	input wire logic composite_sync,
	output logic [7:0] control_out
);
	logic lrst_s, inv_s, asel_s, scl_s, sda_s;
	logic dev_rst_n;

	// Pins from the controller
	dgp_sync2 #(.W(5), .INIT(5'h13)) u_pin_sync (
		.clk(mclk),
		.rstn(rstn),
		.d({link.link_rst_n, link.sample_phase_invert_in, link.bus_address_select,
			link.scl, link.sda}),
		.q({lrst_s, inv_s, asel_s, scl_s, sda_s})
	);

	// Board reset or link reset clears everything past the synchroniser
	assign dev_rst_n = rstn & lrst_s;

	logic [7:0] ctrl;
	logic dual, xhalf, comp;
	dgp_src_e src_sel;
	assign dual = ctrl[CTRL_DUAL];
	assign xhalf = ctrl[CTRL_XHALF];
	assign src_sel = dgp_src_e'(ctrl[CTRL_SRC +: 2]);
	assign comp = (src_sel == dgp_src_comp);

	// Crystal clock buffer, full or half rate
	logic [1:0] xcnt, next_xcnt;
	logic xclk, next_xclk, xrate, next_xrate;
	always_comb begin
		next_xcnt = xcnt + 2'h1;
		next_xclk = xclk;
		next_xrate = xrate;
		if (xcnt == (xrate ? XTAL_HALF_TGL_M1 : XTAL_TGL_M1)) begin
			next_xcnt = 2'h0;
			next_xclk = !xclk;
			// Rate change waits for a rise so no period is cut short
			if (!xclk)
				next_xrate = xhalf;
		end
	end
	always_ff @(posedge mclk or negedge dev_rst_n) begin
		if (!dev_rst_n) begin
			xcnt <= 2'h0;
			xclk <= 1'b0;
			xrate <= 1'b0;
		end else begin
			xcnt <= next_xcnt;
			xclk <= next_xclk;
			xrate <= next_xrate;
		end
	end

	// Pixel timing, sync processing and output launch
	logic [1:0] ph, next_ph;
	logic pix_en, smp_en, src, pair, next_pair;
	logic [23:0] smp, next_smp, hold, next_hold, pri, next_pri, sec, next_sec;
	logic dclk, next_dclk, dclk_n, next_dclk_n;
	logic src_d, next_src_d, disrupt, next_disrupt;
	logic [7:0] wcnt, next_wcnt;
	logic [11:0] lcnt, next_lcnt, period, next_period;
	logic hs, next_hs, rf, next_rf, fpend, next_fpend;
	logic dact, next_dact, vs, next_vs;
	logic [3:0] dcnt, next_dcnt;
	logic hs_o, next_hs_o, vs_o, next_vs_o;
	logic rawh, next_rawh, rawv, next_rawv;
	logic dual_px, next_dual_px;

	always_comb begin
		case (src_sel)
			dgp_src_green: src = green_embedded_sync;
			dgp_src_comp: src = composite_sync;
			default: src = line_sync_in;
		endcase
		next_ph = (ph == PIX_DIV_M1) ? 2'h0 : ph + 2'h1;
		pix_en = (ph == PIX_DIV_M1);
		smp_en = (ph == (inv_s ? PIX_HALF : 2'h0));
		next_smp = smp_en ? {adc_red, adc_green, adc_blue} : smp;
		next_rawh = src;
		next_rawv = comp ? disrupt : frame_sync_in;
		next_pair = pair;
		next_dual_px = dual_px;
		next_hold = hold;
		next_pri = pri;
		next_sec = sec;
		next_src_d = src_d;
		next_wcnt = wcnt;
		next_disrupt = disrupt;
		next_lcnt = lcnt;
		next_period = period;
		next_hs = hs;
		next_rf = rf;
		next_fpend = fpend;
		next_dact = dact;
		next_dcnt = dcnt;
		next_vs = vs;
		next_hs_o = hs_o;
		next_vs_o = vs_o;
		if (pix_en) begin
			next_src_d = src;
			// Broad pulses on a composite source mark the vertical interval
			next_wcnt = !src ? 8'h00 : (wcnt == BROAD_PIX) ? wcnt : wcnt + 8'h01;
			if (comp && src && wcnt == BROAD_PIX)
				next_disrupt = 1'b1;
			else if (!comp || (!src && src_d && wcnt < BROAD_PIX))
				next_disrupt = 1'b0;
			// Flywheel line timer keeps pure line sync through disruption
			next_lcnt = lcnt + 12'h001;
			if (src && !src_d && !disrupt && !hs) begin
				next_period = lcnt;
				next_lcnt = 12'h000;
			end else if (disrupt && period != 12'h000 && lcnt >= period) begin
				next_lcnt = 12'h000;
			end
			next_hs = (next_period != 12'h000) && (next_lcnt < LINE_SYNC_PIX);
			// Frame sync follows line sync end by a fixed delay
			next_rf = rawv;
			if (hs && !next_hs) begin
				next_dact = 1'b1;
				next_dcnt = 4'h1;
			end else if (dact) begin
				next_dcnt = dcnt + 4'h1;
				if (dcnt == FRAME_DLY_PIX) begin
					next_dact = 1'b0;
					next_vs = fpend;
					next_fpend = 1'b0;
				end
			end
			if (rawv && !rf)
				next_fpend = 1'b1;
			// Launch data with the syncs on one word clock edge
			// Mode change only at a word boundary, keeping clock halves whole
			next_dual_px = (pair || !dual_px) ? dual : dual_px;
			next_pair = dual_px ? !pair : 1'b0;
			if (!dual_px) begin
				next_pri = smp;
				next_sec = 24'h000000;
				next_hs_o = hs;
				next_vs_o = vs;
			end else if (!pair) begin
				next_hold = smp;
			end else begin
				next_pri = hold;
				next_sec = smp;
				next_hs_o = hs;
				next_vs_o = vs;
			end
		end
		next_dclk = dual_px ? !next_pair : (next_ph < PIX_HALF);
		next_dclk_n = !next_dclk;
	end

	always_ff @(posedge mclk or negedge dev_rst_n) begin
		if (!dev_rst_n) begin
			ph <= PIX_DIV_M1;
			pair <= 1'b0;
			dual_px <= 1'b0;
			smp <= 24'h000000;
			hold <= 24'h000000;
			pri <= 24'h000000;
			sec <= 24'h000000;
			dclk <= 1'b0;
			dclk_n <= 1'b1;
			src_d <= 1'b0;
			wcnt <= 8'h00;
			disrupt <= 1'b0;
			lcnt <= 12'h000;
			period <= 12'h000;
			hs <= 1'b0;
			rf <= 1'b0;
			fpend <= 1'b0;
			dact <= 1'b0;
			dcnt <= 4'h0;
			vs <= 1'b0;
			hs_o <= 1'b0;
			vs_o <= 1'b0;
			rawh <= 1'b0;
			rawv <= 1'b0;
		end else begin
			ph <= next_ph;
			pair <= next_pair;
			dual_px <= next_dual_px;
			smp <= next_smp;
			hold <= next_hold;
			pri <= next_pri;
			sec <= next_sec;
			dclk <= next_dclk;
			dclk_n <= next_dclk_n;
			src_d <= next_src_d;
			wcnt <= next_wcnt;
			disrupt <= next_disrupt;
			lcnt <= next_lcnt;
			period <= next_period;
			hs <= next_hs;
			rf <= next_rf;
			fpend <= next_fpend;
			dact <= next_dact;
			dcnt <= next_dcnt;
			vs <= next_vs;
			hs_o <= next_hs_o;
			vs_o <= next_vs_o;
			rawh <= next_rawh;
			rawv <= next_rawv;
		end
	end

	// Serial control slave: one control byte written, status byte read
	dgp_slv_e st, next_st;
	logic scl_d, sda_d, rw, next_rw, oe, next_oe;
	logic [3:0] bitc, next_bitc;
	logic [7:0] sh, next_sh, next_ctrl, status;
	logic rise, fall, start, stop;
	assign status = {4'h0, disrupt, inv_s, rawv, rawh};

	always_comb begin
		rise = scl_s && !scl_d;
		fall = !scl_s && scl_d;
		start = scl_s && scl_d && sda_d && !sda_s;
		stop = scl_s && scl_d && !sda_d && sda_s;
		next_st = st;
		next_rw = rw;
		next_oe = oe;
		next_bitc = bitc;
		next_sh = sh;
		next_ctrl = ctrl;
		if (start) begin
			next_st = slv_addr;
			next_bitc = 4'h0;
			next_oe = 1'b0;
		end else if (stop) begin
			next_st = slv_idle;
			next_oe = 1'b0;
		end else if (rise) begin
			if (st == slv_addr || st == slv_wr) begin
				next_sh = {sh[6:0], sda_s};
				next_bitc = bitc + 4'h1;
			end else if (st == slv_ackr && sda_s) begin
				next_st = slv_idle;
			end
		end else if (fall) begin
			case (st)
				slv_addr: if (bitc == 4'h8) begin
					if (sh[7:1] == (asel_s ? ADDR_SEL_HIGH : ADDR_SEL_LOW)) begin
						next_st = slv_acka;
						next_rw = sh[0];
						next_oe = 1'b1;
					end else begin
						next_st = slv_idle;
					end
				end
				slv_acka, slv_ackr: begin
					next_bitc = 4'h0;
					if (st == slv_ackr || rw) begin
						next_st = slv_rd;
						next_sh = status;
						next_oe = !status[7];
					end else begin
						next_st = slv_wr;
						next_oe = 1'b0;
					end
				end
				slv_wr: if (bitc == 4'h8) begin
					next_ctrl = sh;
					next_st = slv_ackw;
					next_oe = 1'b1;
				end
				slv_ackw: begin
					next_bitc = 4'h0;
					next_oe = 1'b0;
					next_st = slv_wr;
				end
				slv_rd: if (bitc == 4'h7) begin
					next_st = slv_ackr;
					next_oe = 1'b0;
				end else begin
					next_sh = {sh[6:0], 1'b0};
					next_oe = !sh[6];
					next_bitc = bitc + 4'h1;
				end
				default: next_st = slv_idle;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge dev_rst_n) begin
		if (!dev_rst_n) begin
			st <= slv_idle;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			rw <= 1'b0;
			oe <= 1'b0;
			bitc <= 4'h0;
			sh <= 8'h00;
			ctrl <= CTRL_RESET;
		end else begin
			st <= next_st;
			scl_d <= scl_s;
			sda_d <= sda_s;
			rw <= next_rw;
			oe <= next_oe;
			bitc <= next_bitc;
			sh <= next_sh;
			ctrl <= next_ctrl;
		end
	end

	// Pin and user outputs
	assign control_out = ctrl;
	assign link.crystal_clock_buffer_out = xclk;
	assign link.sda_o_dev = 1'b0;
	assign link.sda_oe_dev = oe;
	assign link.red_pri = pri[23:16];
	assign link.grn_pri = pri[15:8];
	assign link.blu_pri = pri[7:0];
	assign link.red_sec = sec[23:16];
	assign link.grn_sec = sec[15:8];
	assign link.blu_sec = sec[7:0];
	assign link.pixel_word_clock = dclk;
	assign link.pixel_word_clock_n = dclk_n;
	assign link.aligned_line_sync_out = hs_o;
	assign link.synthetic_frame_sync_out = vs_o;
	assign link.raw_line_sync_out = rawh;
	assign link.raw_frame_sync_out = rawv;
endmodule : dgp_device
`default_nettype wire

// ===== hdl/dgp_controller.sv
// Controller end: serial master, reset and phase control, pixel capture
`timescale 1ns/10ps
`default_nettype none
module dgp_controller
	import dgp_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	dgp_link_if.ctl link,
	input wire logic addr_sel,
	input wire logic undersample_en,
	input wire logic reset_req,
	input wire logic cmd_valid,
	input wire logic cmd_read,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack,
	output logic px_valid,
	output logic [23:0] px_pri,
	output logic [23:0] px_sec,
	output logic line_start,
	output logic frame_start
);
	logic [47:0] d_s;
	logic dclk_s, hs_s, vs_s, rawv_s, sda_s;

	dgp_sync2 #(.W(53), .INIT(53'h1)) u_pin_sync (
		.clk(mclk),
		.rstn(rstn),
		.d({link.red_pri, link.grn_pri, link.blu_pri, link.red_sec, link.grn_sec,
			link.blu_sec, link.pixel_word_clock, link.aligned_line_sync_out,
			link.synthetic_frame_sync_out, link.raw_frame_sync_out, link.sda}),
		.q({d_s, dclk_s, hs_s, vs_s, rawv_s, sda_s})
	);

	// Capture on the word clock fall, mid-way through stable data
	logic dclk_d, rawv_d, hs_p, vs_p, inv, next_inv, lrst, next_lrst;
	logic next_px_valid, next_line_start, next_frame_start, asel;
	logic [23:0] next_px_pri, next_px_sec;
	logic [7:0] rcnt, next_rcnt;
	always_comb begin
		next_px_valid = dclk_d && !dclk_s;
		next_px_pri = next_px_valid ? d_s[47:24] : px_pri;
		next_px_sec = next_px_valid ? d_s[23:0] : px_sec;
		next_line_start = next_px_valid && hs_s && !hs_p;
		next_frame_start = next_px_valid && vs_s && !vs_p;
		next_inv = !undersample_en ? 1'b0 : (rawv_s && !rawv_d) ? !inv : inv;
		next_rcnt = reset_req ? RST_LOW_CYC : (rcnt != 8'h00) ? rcnt - 8'h01 : rcnt;
		next_lrst = (next_rcnt == 8'h00);
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dclk_d <= 1'b0;
			rawv_d <= 1'b0;
			hs_p <= 1'b0;
			vs_p <= 1'b0;
			inv <= 1'b0;
			rcnt <= 8'h00;
			lrst <= 1'b1;
			asel <= 1'b0;
			px_valid <= 1'b0;
			px_pri <= 24'h000000;
			px_sec <= 24'h000000;
			line_start <= 1'b0;
			frame_start <= 1'b0;
		end else begin
			dclk_d <= dclk_s;
			rawv_d <= rawv_s;
			hs_p <= next_px_valid ? hs_s : hs_p;
			vs_p <= next_px_valid ? vs_s : vs_p;
			inv <= next_inv;
			rcnt <= next_rcnt;
			lrst <= next_lrst;
			asel <= addr_sel;
			px_valid <= next_px_valid;
			px_pri <= next_px_pri;
			px_sec <= next_px_sec;
			line_start <= next_line_start;
			frame_start <= next_frame_start;
		end
	end

	// Serial master: start, address, one data byte, stop
	dgp_mst_e mst, next_mst;
	logic [7:0] qc, next_qc;
	logic [1:0] q, next_q;
	logic [4:0] bitn, next_bitn;
	logic [17:0] tx, next_tx, rx, next_rx;
	logic scl, next_scl, oe, next_oe, rd, next_rd, tick;
	logic next_cmd_ready, next_rsp_valid, next_rsp_nack;
	logic [7:0] next_rsp_data;
	always_comb begin
		tick = (qc == I2C_QTR_M1);
		next_qc = (mst == mst_idle || tick) ? 8'h00 : qc + 8'h01;
		next_q = tick ? q + 2'h1 : q;
		next_mst = mst;
		next_bitn = bitn;
		next_tx = tx;
		next_rx = rx;
		next_rd = rd;
		next_scl = scl;
		next_oe = oe;
		next_cmd_ready = 1'b0;
		next_rsp_valid = 1'b0;
		next_rsp_nack = rsp_nack;
		next_rsp_data = rsp_data;
		case (mst)
			mst_idle: begin
				next_scl = 1'b1;
				next_oe = 1'b0;
				next_q = 2'h0;
				next_cmd_ready = !cmd_valid;
				if (cmd_valid && cmd_ready) begin
					next_mst = mst_start;
					next_rd = cmd_read;
					next_tx = {asel ? ADDR_SEL_HIGH : ADDR_SEL_LOW, cmd_read, 1'b1,
						cmd_read ? 8'hff : cmd_data, 1'b1};
				end
			end
			mst_start: if (tick) begin
				if (q == 2'h0)
					next_oe = 1'b1;
				if (q == 2'h1) begin
					next_scl = 1'b0;
					next_mst = mst_bits;
					next_q = 2'h0;
					next_bitn = 5'h00;
				end
			end
			mst_bits: if (tick) begin
				case (q)
					2'h0: next_oe = !tx[17];
					2'h1: next_scl = 1'b1;
					2'h2: next_rx = {rx[16:0], sda_s};
					default: begin
						next_scl = 1'b0;
						next_tx = {tx[16:0], 1'b1};
						next_bitn = bitn + 5'h01;
						if (bitn == I2C_LAST_BIT)
							next_mst = mst_stop;
					end
				endcase
			end
			mst_stop: if (tick) begin
				case (q)
					2'h0: next_oe = 1'b1;
					2'h1: next_scl = 1'b1;
					2'h2: next_oe = 1'b0;
					default: begin
						next_mst = mst_idle;
						next_rsp_valid = 1'b1;
						next_rsp_data = rd ? rx[8:1] : 8'h00;
						next_rsp_nack = rx[9] || (!rd && rx[0]);
					end
				endcase
			end
			default: next_mst = mst_idle;
		endcase
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mst <= mst_idle;
			qc <= 8'h00;
			q <= 2'h0;
			bitn <= 5'h00;
			tx <= 18'h3ffff;
			rx <= 18'h00000;
			rd <= 1'b0;
			scl <= 1'b1;
			oe <= 1'b0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_nack <= 1'b0;
			rsp_data <= 8'h00;
		end else begin
			mst <= next_mst;
			qc <= next_qc;
			q <= next_q;
			bitn <= next_bitn;
			tx <= next_tx;
			rx <= next_rx;
			rd <= next_rd;
			scl <= next_scl;
			oe <= next_oe;
			cmd_ready <= next_cmd_ready;
			rsp_valid <= next_rsp_valid;
			rsp_nack <= next_rsp_nack;
			rsp_data <= next_rsp_data;
		end
	end

	assign link.sample_phase_invert_in = inv;
	assign link.link_rst_n = lrst;
	assign link.bus_address_select = asel;
	assign link.scl = scl;
	assign link.sda_o_ctl = 1'b0;
	assign link.sda_oe_ctl = oe;
endmodule : dgp_controller
`default_nettype wire

// ===== sim/dgp_chk.sv
// Concurrent checks on the digitizer link signals
`timescale 1ns/10ps
`default_nettype none
module dgp_chk
	import dgp_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic link_rst_n,
	input wire logic scl,
	input wire logic sda_o_dev,
	input wire logic sda_oe_dev,
	input wire logic sda_o_ctl,
	input wire logic sda_oe_ctl,
	input wire logic crystal_clock_buffer_out,
	input wire logic [7:0] red_pri,
	input wire logic pixel_word_clock,
	input wire logic pixel_word_clock_n,
	input wire logic aligned_line_sync_out,
	input wire logic synthetic_frame_sync_out
);
	logic [3:0] lr_hist, next_lr_hist;
	logic [11:0] hs_w, next_hs_w, fall_cnt, next_fall_cnt, lo_cnt, next_lo_cnt;
	// Counters for sync width, delay after sync and link reset length
	always_comb begin
		next_lr_hist = {lr_hist[2:0], link_rst_n};
		next_hs_w = aligned_line_sync_out ? hs_w + 12'h001 : 12'h000;
		next_fall_cnt = aligned_line_sync_out ? 12'h000 : fall_cnt + {11'h000, fall_cnt != 12'hfff};
		next_lo_cnt = link_rst_n ? 12'h000 : lo_cnt + 12'h001;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lr_hist <= 4'hf;
			hs_w <= 12'h000;
			fall_cnt <= 12'h000;
			lo_cnt <= 12'h000;
		end else begin
			lr_hist <= next_lr_hist;
			hs_w <= next_hs_w;
			fall_cnt <= next_fall_cnt;
			lo_cnt <= next_lo_cnt;
		end
	end
	// Device outputs jump to reset values around a link reset
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn || !(&lr_hist));
	sequence s_word_fast;
		pixel_word_clock[*2] ##1 !pixel_word_clock;
	endsequence
	sequence s_word_dual;
		pixel_word_clock[*4] ##1 !pixel_word_clock;
	endsequence
	sequence s_xtal_full;
		crystal_clock_buffer_out[*2] ##1 !crystal_clock_buffer_out;
	endsequence
	sequence s_xtal_half;
		crystal_clock_buffer_out[*4] ##1 !crystal_clock_buffer_out;
	endsequence
	chk_word_inverse: assert property (pixel_word_clock_n != pixel_word_clock)
		else $error("inverse word clock equals word clock");
	chk_sda_pull_only: assert property (!(sda_oe_dev && sda_o_dev) && !(sda_oe_ctl && sda_o_ctl))
		else $error("serial data driven high");
	chk_ack_scl_low: assert property ($changed(sda_oe_dev) |-> !scl)
		else $error("device changed serial data while clock high");
	chk_word_period: assert property ($rose(pixel_word_clock) |-> s_word_fast or s_word_dual)
		else $error("word clock high time wrong");
	chk_xtal_period: assert property ($rose(crystal_clock_buffer_out) |-> s_xtal_full or s_xtal_half)
		else $error("crystal clock high time wrong");
	chk_same_edge_launch: assert property (($changed(red_pri) || $changed(aligned_line_sync_out)
		|| $changed(synthetic_frame_sync_out)) |-> $rose(pixel_word_clock))
		else $error("data or sync changed off the word clock rise");
	chk_frame_delay: assert property ($rose(synthetic_frame_sync_out)
		|-> fall_cnt == {6'h00, FRAME_DLY_PIX, 2'h0})
		else $error("frame sync not 8 pixels after line sync end");
	chk_line_width: assert property ($fell(aligned_line_sync_out)
		|-> hs_w == {LINE_SYNC_PIX[9:0], 2'h0})
		else $error("aligned line sync width wrong");
	chk_link_rst_len: assert property (disable iff (!rstn)
		$rose(link_rst_n) |-> lo_cnt == {4'h0, RST_LOW_CYC})
		else $error("link reset low time wrong");
endmodule : dgp_chk
`default_nettype wire

// ===== sim/digitizer_pixel_sync_output_port_bench.sv
// Bench joining both link ends, driven from their user sides
`timescale 1ns/10ps
`default_nettype none
module digitizer_pixel_sync_output_port_bench
	import dgp_pkg::*;
();
	logic mclk, rstn, addr_sel, undersample_en, reset_req, cmd_valid, cmd_read;
	logic [7:0] cmd_data, adc_red, adc_green, adc_blue, rsp_data, control_out;
	logic line_sync_in, frame_sync_in, green_embedded_sync, composite_sync, broad;
	logic cmd_ready, rsp_valid, rsp_nack, px_valid, line_start, frame_start, old;
	logic [23:0] px_pri, px_sec;
	int num_errors, checked, pos, lno, i, p, m, s;
	dgp_link_if link();
	dgp_device dgp_device_inst(.mclk, .rstn, .link(link.dev), .adc_red, .adc_green, .adc_blue,
		.line_sync_in, .frame_sync_in, .green_embedded_sync, .composite_sync, .control_out);
	dgp_controller dgp_controller_inst(.mclk, .rstn, .link(link.ctl), .addr_sel, .undersample_en,
		.reset_req, .cmd_valid, .cmd_read, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .rsp_nack,
		.px_valid, .px_pri, .px_sec, .line_start, .frame_start);
	dgp_chk dgp_chk_inst(.mclk, .rstn, .link_rst_n(link.link_rst_n), .scl(link.scl),
		.sda_o_dev(link.sda_o_dev), .sda_oe_dev(link.sda_oe_dev), .sda_o_ctl(link.sda_o_ctl),
		.sda_oe_ctl(link.sda_oe_ctl), .crystal_clock_buffer_out(link.crystal_clock_buffer_out),
		.red_pri(link.red_pri), .pixel_word_clock(link.pixel_word_clock),
		.pixel_word_clock_n(link.pixel_word_clock_n), .aligned_line_sync_out(link.aligned_line_sync_out),
		.synthetic_frame_sync_out(link.synthetic_frame_sync_out));
	// Free-running clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Source syncs: 400-cycle lines, eight lines a frame, optional broad pulse
	always @(negedge mclk) begin
		pos = (pos + 1) % 400;
		if (pos == 0) lno = (lno + 1) % 8;
		line_sync_in = pos < 32;
		green_embedded_sync = pos >= 8 && pos < 40;
		composite_sync = pos < (broad ? 300 : 24);
		frame_sync_in = lno == 0;
	end
	// Expected pixel word and expected raw line sync
	function automatic logic [23:0] exp_px();
		return {adc_red, adc_green, adc_blue};
	endfunction : exp_px
	function automatic logic src_of(input int sel);
		return sel == 0 ? line_sync_in : sel == 1 ? green_embedded_sync : composite_sync;
	endfunction : src_of
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : cmp
	task automatic expire(input int n, input int lim);
		if (n >= lim) begin
			num_errors++;
			$display("[ERR] t=%0t wait ran out seen=%h exp=%h", $time, n, lim);
			stop_test();
		end
	endtask : expire
	// One serial command: hold valid until taken, then await the answer
	task automatic serial(input logic rd, input logic [7:0] d);
		int k;
		cmd_read = rd;
		cmd_data = d;
		cmd_valid = 1'b1;
		for (k = 0; k < 20 && cmd_ready !== 1'b1; k++) @(negedge mclk);
		expire(k, 20);
		@(negedge mclk);
		cmd_valid = 1'b0;
		for (k = 0; k < 6000 && rsp_valid !== 1'b1; k++) @(negedge mclk);
		expire(k, 6000);
		repeat (3) @(negedge mclk);
	endtask : serial
	// Crystal clock period in cycles, rise to rise
	task automatic xtal_period(output int per);
		int k;
		for (k = 0; k < 50 && link.crystal_clock_buffer_out !== 1'b0; k++) @(negedge mclk);
		for (k = 0; k < 50 && link.crystal_clock_buffer_out !== 1'b1; k++) @(negedge mclk);
		for (per = 0; per < 50 && link.crystal_clock_buffer_out !== 1'b0; per++) @(negedge mclk);
		for (; per < 50 && link.crystal_clock_buffer_out !== 1'b1; per++) @(negedge mclk);
	endtask : xtal_period
	initial begin
		{addr_sel, undersample_en, reset_req, cmd_valid, cmd_read, broad, rstn} = '0;
		{cmd_data, adc_red, adc_green, adc_blue} = '0;
		{line_sync_in, frame_sync_in, green_embedded_sync, composite_sync} = '0;
		{num_errors, checked, pos, lno} = '0;
		void'($urandom(32'hf7b2));
		repeat (10) @(negedge mclk);
		rstn = 1'b1;
		// Both address selects, write then read, crystal rate
		for (m = 0; m < 2; m++) begin
			addr_sel = m[0];
			repeat (5) @(negedge mclk);
			cmp(link.bus_address_select, m);
			cmd_data = 8'($urandom) & 8'h08;
			serial(1'b0, cmd_data);
			cmp(rsp_nack, 0);
			cmp(control_out, cmd_data);
			xtal_period(p);
			cmp(p, cmd_data[3] ? 8 : 4);
			serial(1'b1, 8'h00);
			cmp({rsp_nack, rsp_data[7:4]}, 0);
		end
		$display("test address done");
		// Pixel words in both output modes
		for (m = 0; m < 2; m++) begin
			serial(1'b0, 8'(m));
			{adc_red, adc_green, adc_blue} = 24'($urandom);
			repeat (60) @(negedge mclk);
			for (i = 0; i < 50 && px_valid !== 1'b1; i++) @(negedge mclk);
			expire(i, 50);
			cmp(px_pri, exp_px());
			cmp(px_sec, m ? exp_px() : 24'h0);
			cmp({link.red_pri, link.grn_pri, link.blu_pri}, exp_px());
		end
		$display("test pixel done");
		// Link reset from the controller clears the control byte
		reset_req = 1'b1;
		@(negedge mclk);
		reset_req = 1'b0;
		for (i = 0; i < 10 && link.link_rst_n !== 1'b0; i++) @(negedge mclk);
		expire(i, 10);
		for (p = 0; p < 200 && link.link_rst_n !== 1'b1; p++) @(negedge mclk);
		cmp(p, 100);
		repeat (10) @(negedge mclk);
		cmp(control_out, 8'h00);
		$display("test reset done");
		// Every sync source on the raw line output, then aligned syncs
		for (s = 0; s < 3; s++) begin
			serial(1'b0, 8'(s << 1));
			for (i = 0; i < 800; i++) begin
				@(posedge mclk);
				#2 cmp(link.raw_line_sync_out, src_of(s));
			end
			@(negedge mclk);
			broad = (s == 2);
			for (i = 0; i < 4000 && frame_start !== 1'b1; i++) @(negedge mclk);
			expire(i, 4000);
			cmp({line_start, link.synthetic_frame_sync_out}, 2'h1);
			for (i = 0; i < 600 && line_start !== 1'b1; i++) @(negedge mclk);
			expire(i, 600);
			cmp(link.aligned_line_sync_out, 1);
			broad = 1'b0;
		end
		repeat (900) @(negedge mclk);
		cmp(link.raw_frame_sync_out, 0);
		broad = 1'b1;
		for (i = 0; i < 1200 && link.raw_frame_sync_out !== 1'b1; i++) @(negedge mclk);
		cmp(i < 1200, 1);
		broad = 1'b0;
		repeat (900) @(negedge mclk);
		$display("test sync done");
		// Phase flips once per frame sync while undersampling
		serial(1'b0, 8'h00);
		undersample_en = 1'b1;
		for (i = 0; i < 4000 && link.raw_frame_sync_out !== 1'b0; i++) @(negedge mclk);
		for (i = 0; i < 4000 && link.raw_frame_sync_out !== 1'b1; i++) @(negedge mclk);
		expire(i, 4000);
		old = link.sample_phase_invert_in;
		repeat (20) @(negedge mclk);
		cmp(link.sample_phase_invert_in, !old);
		undersample_en = 1'b0;
		repeat (10) @(negedge mclk);
		cmp(link.sample_phase_invert_in, 0);
		$display("test phase done");
		stop_test();
	end
endmodule : digitizer_pixel_sync_output_port_bench
`default_nettype wire
